// ==== hdl/capture_fifo.sv ====
// capture buffer: flip-flop storage, drops pushes while full
`timescale 1ns/1ps
module capture_fifo
  import capture_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_DEFAULT
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // buffer side
  fifo_if.store    bus
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FILL_MAX = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  logic [15:0]   store_word [DEPTH];  // entries
  logic [PW-1:0] write_ptr;           // next free slot
  logic [PW-1:0] read_ptr;            // oldest slot
  logic [PW:0]   fill;                // entries held
  logic          do_push;
  logic          do_pop;

  // full buffer keeps its contents
  assign do_push = bus.push && (fill != FILL_MAX);
  assign do_pop  = bus.pop && (fill != '0);

  // status towards the unit
  assign bus.pop_data  = store_word[read_ptr];
  assign bus.not_empty = (fill != '0);
  assign bus.full      = (fill == FILL_MAX);

  // pointer step with wrap
  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    ptr_step = (p == PTR_LAST) ? '0 : p + PW'(1);
  endfunction : ptr_step

  // storage write
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      store_word[write_ptr] <= bus.push_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      write_ptr <= '0;
      read_ptr  <= '0;
      fill      <= '0;
    end else begin
      if (do_push) begin
        write_ptr <= ptr_step(write_ptr);
      end
      if (do_pop) begin
        read_ptr <= ptr_step(read_ptr);
      end
      fill <= fill + (PW + 1)'(do_push) - (PW + 1)'(do_pop);
    end
  end

  full_keep_a: assert property (@(posedge sys_clk) disable iff (srst)
    bus.full && bus.push && !bus.pop |=> bus.full && $stable(write_ptr))
    else $error("push into full buffer changed it");
  bne_set_a: assert property (@(posedge sys_clk) disable iff (srst)
    bus.push && !bus.not_empty |=> bus.not_empty)
    else $error("not-empty flag missing after capture");
  last_pop_a: assert property (@(posedge sys_clk) disable iff (srst)
    bus.pop && !bus.push && fill == (PW + 1)'(1) |=> !bus.not_empty)
    else $error("not-empty flag stuck after last read");
endmodule : capture_fifo

// ==== hdl/capture_pkg.sv ====
// capture unit constants, register map and mode encodings
// How it works
// - cascade: odd low half, even high, carry
// - cascade only with bit 8 in both
// - capture rising, any edge, 4th, 16th
// - interrupt rate field picks event subset
// - not-empty flag shows stored captures
// - buffer read pops; flag clears when empty
// - sync select zero means free running
// - time base select picks counted source
// - trigger bit picks mode; software clears status
// - capture mode field picks capture behaviour
// - cascaded even follows odd synchronously
// - odd fields govern cascaded capture
// - held in reset until time base and sync source on
// - accept captures once sources enabled
package capture_pkg;
  // byte offsets inside one channel window
  localparam logic [3:0] OFFSET_CONTROL_ONE = 4'h0;
  localparam logic [3:0] OFFSET_CONTROL_TWO = 4'h4;
  localparam logic [3:0] OFFSET_BUFFER      = 4'h8;
  // address layout: bit 4 picks odd (0) or even (1)
  localparam int         AXI_ADDR_WIDTH     = 8;
  localparam int         CHANNEL_ADDR_BIT   = 4;
  localparam logic [2:0] UPPER_ADDR_ZERO    = 3'h0;
  // first control register fields
  localparam int TSEL_LSB = 10;
  localparam int ICI_LSB  = 5;
  localparam int BNE_BIT  = 3;
  localparam int MODE_LSB = 0;
  // second control register fields
  localparam int CASCADE_BIT = 8;
  localparam int TRIG_BIT    = 7;
  localparam int TSTAT_BIT   = 6;
  localparam int SYNC_LSB    = 0;
  // reset values and writable bits
  localparam logic [15:0] CONTROL_RESET   = 16'h0000;
  localparam logic [15:0] ONE_WRITE_MASK  = 16'h1c67;
  localparam logic [15:0] TWO_WRITE_MASK  = 16'h01df;
  // counting constants
  localparam logic [15:0] COUNT_MAX        = 16'hffff;
  localparam logic [3:0]  PRESCALE_FOUR    = 4'h3;
  localparam logic [3:0]  PRESCALE_SIXTEEN = 4'hf;
  localparam logic [4:0]  SYNC_FREE        = 5'h00;
  localparam int          FIFO_DEPTH_DEFAULT = 4;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  // capture mode encodings
  typedef enum logic [2:0] {
    MODE_OFF       = 3'b000,
    MODE_ANY_EDGE  = 3'b001,
    MODE_RISING    = 3'b011,
    MODE_FOURTH    = 3'b100,
    MODE_SIXTEENTH = 3'b101
  } capture_mode_type;
endpackage : capture_pkg

// ==== hdl/fifo_if.sv ====
// bundle between the unit and one capture buffer
`timescale 1ns/1ps
interface fifo_if;
  logic        push;       // store one capture
  logic [15:0] push_data;  // captured count
  logic        pop;        // remove oldest entry
  logic [15:0] pop_data;   // oldest entry
  logic        not_empty;  // at least one entry
  logic        full;       // no room left
  modport store (input push, input push_data, input pop, output pop_data, output not_empty, output full);
  modport feed (output push, output push_data, output pop, input pop_data, input not_empty, input full);
endinterface : fifo_if

// ==== hdl/input_capture_unit.sv ====
// input capture pair: odd and even channels, cascade, axi4-lite registers
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module input_capture_unit
  import capture_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  // axi4-lite write channels
  input  wire logic [AXI_ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read channels
  input  wire logic [AXI_ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // capture pins, index 0 odd, 1 even
  input  wire logic [1:0]                capture_input,
  // time base sources: running level and count pulse
  input  wire logic [7:0]                time_base_enable,
  input  wire logic [7:0]                time_base_tick,
  // sync or trigger sources, index 0 unused
  input  wire logic [31:0]               sync_source_enable,
  input  wire logic [31:0]               sync_source_event,
  // capture interrupt pulses
  output logic [1:0]                     capture_irq
);
  logic [15:0]      capture_control_one [2];  // mode, rate, time base
  logic [15:0]      capture_control_two [2];  // sync, trigger, cascade
  logic [15:0]      count [2];                // capture time base
  logic [3:0]       prescale [2];             // rising edge divider
  logic [1:0]       irq_count [2];            // events since last interrupt
  logic [1:0]       pin_prev;                 // pin one cycle ago
  logic             cascade;                  // 32-bit pairing active
  logic [2:0]       sel_tb [2];               // time base pick
  logic [4:0]       sel_sync [2];             // sync source pick
  logic [1:0]       source_on;                // time base and sync enabled
  logic [1:0]       trig_mode;                // trigger operation
  logic [1:0]       sync_hit;                 // sync event this cycle
  logic [1:0]       run;                      // counter may advance
  logic [1:0]       clear;                    // counter held or reset
  logic [1:0]       tick;                     // own counted pulse
  logic [1:0]       step;                     // counter increment
  logic [1:0]       own_hit;                  // channel's own capture event
  logic [1:0]       cap;                      // capture into buffer
  logic [1:0]       irq_owner;                // channel raises interrupts
  logic [1:0]       push;                     // buffer write
  logic [1:0]       pop;                      // buffer read
  logic [15:0]      pop_data [2];
  logic [1:0]       not_empty;
  logic [1:0]       full;
  capture_mode_type mode [2];
  // bus holding state
  logic [AXI_ADDR_WIDTH-1:0] aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             do_write;

  fifo_if fifo_bus [2] ();

  // pairing needs the bit in both channels
  assign cascade = capture_control_two[0][CASCADE_BIT] & capture_control_two[1][CASCADE_BIT];

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge = (old & ~lanes) | (data[15:0] & lanes);
  endfunction : merge

  // address hits a given channel register
  function automatic logic hit_reg(input logic [AXI_ADDR_WIDTH-1:0] a, input int ch,
                                   input logic [3:0] offs);
    hit_reg = (a[7:5] == UPPER_ADDR_ZERO) && (a[CHANNEL_ADDR_BIT] == ch[0]) && (a[3:0] == offs);
  endfunction : hit_reg

  // per-channel decode of enables, modes and events
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      sel_tb[ch]    = capture_control_one[ch][TSEL_LSB +: 3];
      sel_sync[ch]  = capture_control_two[ch][SYNC_LSB +: 5];
      mode[ch]      = capture_mode_type'(capture_control_one[ch][MODE_LSB +: 3]);
      source_on[ch] = time_base_enable[sel_tb[ch]]
                      & ((sel_sync[ch] == SYNC_FREE) | sync_source_enable[sel_sync[ch]]);
      trig_mode[ch] = (sel_sync[ch] != SYNC_FREE) & capture_control_two[ch][TRIG_BIT];
      sync_hit[ch]  = (sel_sync[ch] != SYNC_FREE) & sync_source_event[sel_sync[ch]];
      case (mode[ch])
        MODE_ANY_EDGE:  own_hit[ch] = capture_input[ch] ^ pin_prev[ch];
        MODE_RISING:    own_hit[ch] = capture_input[ch] & ~pin_prev[ch];
        MODE_FOURTH:    own_hit[ch] = capture_input[ch] & ~pin_prev[ch] & (prescale[ch] == PRESCALE_FOUR);
        MODE_SIXTEENTH: own_hit[ch] = capture_input[ch] & ~pin_prev[ch]
                                      & (prescale[ch] == PRESCALE_SIXTEEN);
        default:        own_hit[ch] = 1'b0;
      endcase
      own_hit[ch] = own_hit[ch] & source_on[ch];
    end
  end

  // run, clear and capture, with even slaved to odd in cascade
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      int m;
      m = (cascade ? 0 : ch);
      run[ch]       = source_on[m] & (~trig_mode[m] | capture_control_two[m][TSTAT_BIT]);
      clear[ch]     = ~source_on[m] | (sync_hit[m] & ~trig_mode[m]);
      tick[ch]      = time_base_tick[sel_tb[ch]] & run[ch];
      cap[ch]       = own_hit[m];
      irq_owner[ch] = ~cascade | (ch == 0);
    end
    step[0] = tick[0];
    step[1] = cascade ? (tick[0] & (count[0] == COUNT_MAX)) : tick[1];
    // a pair is stored whole or not at all
    push[0] = cap[0] & (~cascade | ~full[1]);
    push[1] = cap[1] & (~cascade | ~full[0]);
  end

  // capture counters
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count[0] <= '0;
      count[1] <= '0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (clear[ch]) begin
          count[ch] <= '0;
        end else if (step[ch]) begin
          count[ch] <= count[ch] + 16'h0001;
        end
      end
    end
  end

  // pin history and rising edge dividers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_prev    <= '0;
      prescale[0] <= '0;
      prescale[1] <= '0;
    end else begin
      pin_prev <= capture_input;
      for (int ch = 0; ch < 2; ch++) begin
        if (!source_on[ch] || mode[ch] == MODE_OFF) begin
          prescale[ch] <= '0;                    // held while idle
        end else if (capture_input[ch] && !pin_prev[ch]) begin
          if (mode[ch] == MODE_FOURTH && prescale[ch] == PRESCALE_FOUR) begin
            prescale[ch] <= '0;
          end else begin
            prescale[ch] <= prescale[ch] + 4'h1;
          end
        end
      end
    end
  end

  // interrupt rate divider and registered pulses
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_count[0] <= '0;
      irq_count[1] <= '0;
      capture_irq  <= '0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        capture_irq[ch] <= 1'b0;
        if (cap[ch] && irq_owner[ch]) begin
          if (irq_count[ch] == capture_control_one[ch][ICI_LSB +: 2]) begin
            irq_count[ch]   <= '0;
            capture_irq[ch] <= 1'b1;
          end else begin
            irq_count[ch] <= irq_count[ch] + 2'h1;
          end
        end
      end
    end
  end

  // capture buffers
  for (genvar g = 0; g < 2; g++) begin : g_buf
    assign fifo_bus[g].push      = push[g];
    assign fifo_bus[g].push_data = count[g];  // odd low, even high
    assign fifo_bus[g].pop       = pop[g];
    assign pop_data[g]           = fifo_bus[g].pop_data;
    assign not_empty[g]          = fifo_bus[g].not_empty;
    assign full[g]               = fifo_bus[g].full;
    capture_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk (sys_clk),
      .srst    (srst),
      .bus     (fifo_bus[g])
    );
  end

  // write address and data: taken in either order, response after both
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[7:5] == UPPER_ADDR_ZERO && aw_addr[3:0] != OFFSET_BUFFER
                         && (aw_addr[3:0] == OFFSET_CONTROL_ONE || aw_addr[3:0] == OFFSET_CONTROL_TWO))
                        ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers; trigger status set beats a software clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int ch = 0; ch < 2; ch++) begin
        capture_control_one[ch] <= CONTROL_RESET;
        capture_control_two[ch] <= CONTROL_RESET;
      end
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (do_write && hit_reg(aw_addr, ch, OFFSET_CONTROL_ONE)) begin
          capture_control_one[ch] <= merge(capture_control_one[ch], w_data, w_strb, ONE_WRITE_MASK);
        end
        if (do_write && hit_reg(aw_addr, ch, OFFSET_CONTROL_TWO)) begin
          capture_control_two[ch] <= merge(capture_control_two[ch], w_data, w_strb, TWO_WRITE_MASK);
        end
        if (trig_mode[ch] && sync_hit[ch] && source_on[ch]) begin
          capture_control_two[ch][TSTAT_BIT] <= 1'b1;
        end
      end
    end
  end

  // buffer reads pop one entry at the address handshake
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      pop[ch] = s_axi_arvalid && s_axi_arready && hit_reg(s_axi_araddr, ch, OFFSET_BUFFER);
    end
  end

  // read channel: data one cycle after the address
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_DECERR;
      s_axi_rdata   <= '0;
      for (int ch = 0; ch < 2; ch++) begin
        if (hit_reg(s_axi_araddr, ch, OFFSET_CONTROL_ONE)) begin
          s_axi_rresp <= RESP_OKAY;
          s_axi_rdata <= {16'h0000, capture_control_one[ch] | (16'(not_empty[ch]) << BNE_BIT)};
        end else if (hit_reg(s_axi_araddr, ch, OFFSET_CONTROL_TWO)) begin
          s_axi_rresp <= RESP_OKAY;
          s_axi_rdata <= {16'h0000, capture_control_two[ch]};
        end else if (hit_reg(s_axi_araddr, ch, OFFSET_BUFFER)) begin
          s_axi_rresp <= RESP_OKAY;
          s_axi_rdata <= {16'h0000, pop_data[ch]};  // odd low word, even high word
        end
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  carry_even_a: assert property (@(posedge sys_clk) disable iff (srst)
    cascade && tick[0] && count[0] == COUNT_MAX && !clear[1] |=> count[1] == $past(count[1]) + 16'h0001)
    else $error("even count missed odd wrap");
  solo_even_a: assert property (@(posedge sys_clk) disable iff (srst)
    !cascade && !own_hit[1] |-> !push[1])
    else $error("even buffer written without own event");
  fourth_edge_a: assert property (@(posedge sys_clk) disable iff (srst)
    own_hit[0] && mode[0] == MODE_FOURTH |-> prescale[0] == PRESCALE_FOUR && !pin_prev[0])
    else $error("fourth-edge capture at wrong edge");
  irq_rate_a: assert property (@(posedge sys_clk) disable iff (srst)
    capture_irq[0] |-> $past(cap[0]) && $past(irq_count[0]) == $past(capture_control_one[0][ICI_LSB +: 2]))
    else $error("interrupt at wrong event count");
  hold_reset_a: assert property (@(posedge sys_clk) disable iff (srst)
    !source_on[0] |=> count[0] == 16'h0000 && prescale[0] == 4'h0)
    else $error("counter ran with source disabled");
  trig_wait_a: assert property (@(posedge sys_clk) disable iff (srst)
    source_on[0] && trig_mode[0] && !capture_control_two[0][TSTAT_BIT] && !cascade |=> $stable(count[0]))
    else $error("counter ran before trigger");
  trig_set_a: assert property (@(posedge sys_clk) disable iff (srst)
    trig_mode[0] && sync_hit[0] && source_on[0] |=> capture_control_two[0][TSTAT_BIT])
    else $error("trigger status not set");
  sync_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
    sync_hit[0] && !trig_mode[0] |=> count[0] == 16'h0000)
    else $error("sync event did not reset counter");
endmodule : input_capture_unit

// ==== testbench/edge_source.sv ====
// far side model: capture pin, time bases and sync sources
`timescale 1ns/1ps
module edge_source (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // bench controls
  input  wire logic        run,
  input  wire logic        fire,
  // sources seen by the unit
  output logic [1:0]       capture_input,
  output logic [7:0]       time_base_enable,
  output logic [7:0]       time_base_tick,
  output logic [31:0]      sync_source_enable,
  output logic [31:0]      sync_source_event
);
  logic [1:0] phase;  // toggle divider
  // time bases 0-6 run, 7 stays stopped to show the held counter; all count each cycle
  assign time_base_enable   = 8'h7f;
  assign time_base_tick     = 8'hff;
  // sync sources on, index 0 unused
  assign sync_source_enable = 32'hffff_fffe;
  // odd pin toggles every 4 cycles while running; even pin rests low
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase         <= 2'h0;
      capture_input <= 2'h0;
    end else if (run) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        capture_input[0] <= ~capture_input[0];
      end
    end
  end
  // one-cycle trigger event on source 1
  always_ff @(posedge sys_clk) begin
    sync_source_event <= {30'h0, fire & ~srst, 1'b0};
  end
endmodule : edge_source

// ==== testbench/input_capture_unit_tb.sv ====
// bench: register access, capture modes, buffer drain and trigger status
`timescale 1ns/1ps
module input_capture_unit_tb;
  import capture_pkg::*;
  logic        sys_clk, srst, run, fire;                     // clock, reset, partner controls
  logic [7:0]  s_axi_awaddr, s_axi_araddr;                   // bus addresses
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;                 // data
  logic [3:0]  s_axi_wstrb;                                  // lanes
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, cap_in, irq;   // responses, pins, interrupts
  logic [7:0]  tb_en, tb_tick;                               // time bases
  logic [31:0] sy_en, sy_ev;                                 // sync sources
  logic [15:0] cap [4];                                      // drained captures
  int          num_errors, n_compared;
  int          irq_seen = 0;                                 // odd interrupt pulses seen
  capture_mode_type modes [4] = '{MODE_ANY_EDGE, MODE_RISING, MODE_FOURTH, MODE_SIXTEENTH};
  logic [15:0] gaps [4] = '{16'h0004, 16'h0008, 16'h0020, 16'h0080};
  // design under test
  input_capture_unit #(.FIFO_DEPTH(4)) i_dut (.sys_clk(sys_clk), .srst(srst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .capture_input(cap_in),
    .time_base_enable(tb_en), .time_base_tick(tb_tick), .sync_source_enable(sy_en),
    .sync_source_event(sy_ev), .capture_irq(irq));
  // far side sources
  edge_source i_src (.sys_clk(sys_clk), .srst(srst), .run(run), .fire(fire), .capture_input(cap_in),
    .time_base_enable(tb_en), .time_base_tick(tb_tick), .sync_source_enable(sy_en),
    .sync_source_event(sy_ev));
  // verdict and end of run
  task automatic tally_and_finish;
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // value comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // bus wait exhausted
  task automatic hang;
    num_errors++;
    $display("Error bus answer expected 1 seen 0");
    tally_and_finish();
  endtask : hang
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wvalid  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) hang();
    rsp = s_axi_bresp;
  endtask : wr
  // read: address held until taken, data taken with rvalid
  task automatic rdr(input logic [7:0] a);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) hang();
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rdr
  // read and compare one register
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    rdr(a);
    chk(what, exp, rd);
  endtask : rchk
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // count odd interrupt pulses
  always @(posedge sys_clk) begin
    if (irq[0]) irq_seen <= irq_seen + 1;
  end
  // main sequence
  initial begin
    {srst, run, fire, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 6'b100000;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    num_errors = 0;
    n_compared = 0;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rchk(8'h00, 32'h0, "control_one reset");
    rchk(8'h14, 32'h0, "control_two reset");
    wr(8'h00, 16'hffff); // stopped time base holds the counter
    rchk(8'h00, {16'h0, ONE_WRITE_MASK}, "control_one fields");
    wr(8'h14, 16'hffff);
    rchk(8'h14, {16'h0, TWO_WRITE_MASK}, "control_two fields");
    wr(8'h00, 16'h0000);
    wr(8'h14, 16'h0000);
    rdr(8'h0c);
    chk("unmapped read response", {30'h0, RESP_DECERR}, {30'h0, rsp});
    wr(8'h08, 16'h1234);
    chk("buffer write response", {30'h0, RESP_DECERR}, {30'h0, rsp});
    // each capture mode: fill past full, then drain
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, {13'h0, modes[m]});
      run <= 1'b1;
      repeat (700) @(posedge sys_clk);
      run <= 1'b0;
      rchk(8'h00, {28'h0, 1'b1, modes[m]}, "not empty set");
      for (int k = 0; k < 4; k++) begin
        rdr(8'h08);
        cap[k] = rd[15:0];
      end
      chk("capture spacing early", {16'h0, gaps[m]}, {16'h0, cap[1] - cap[0]});
      chk("capture spacing late", {16'h0, gaps[m]}, {16'h0, cap[3] - cap[2]});
      rchk(8'h00, {29'h0, modes[m]}, "not empty cleared");
      // every transition: one interrupt per capture, 700 cycles over a 4-cycle toggle
      if (m == 0) chk("interrupt count", 32'h0000_00af, irq_seen);
    end
    // trigger status set by the selected event, cleared by software
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h0081);
    rchk(8'h04, 32'h81, "trigger status idle");
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rchk(8'h04, 32'hc1, "trigger status set");
    wr(8'h04, 16'h0081);
    rchk(8'h04, 32'h81, "trigger status cleared");
    // cascade: even first, same sources, odd fields govern; sync event clears both counters
    wr(8'h14, 16'h0101);
    wr(8'h04, 16'h0101);
    wr(8'h00, {13'h0, MODE_RISING});
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (70000) @(posedge sys_clk);
    run <= 1'b1;
    repeat (24) @(posedge sys_clk);
    run <= 1'b0;
    for (int k = 0; k < 4; k += 2) begin
      rdr(8'h08);
      cap[k] = rd[15:0];
      rdr(8'h18);
      cap[k + 1] = rd[15:0];
    end
    chk("cascade high word", 32'h1, {16'h0, cap[1]});
    chk("cascade spacing", 32'h8, {cap[3], cap[2]} - {cap[1], cap[0]});
    tally_and_finish();
  end
endmodule : input_capture_unit_tb
